// File: dag_pkg.sv
// shared constants, register map and carrier types of the alarm grading block
package dag_pkg;

    // timing
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned TICK_MS      = 10;
    localparam int unsigned TICK_CYCLES  = TICK_MS * CLK_MHZ * 1000;

    // register byte offsets
    localparam logic [7:0] OFF_SEL1      = 8'h00;
    localparam logic [7:0] OFF_SEL2      = 8'h04;
    localparam logic [7:0] OFF_SEL3      = 8'h08;
    localparam logic [7:0] OFF_SEL4      = 8'h0c;
    localparam logic [7:0] OFF_CTRL      = 8'h10;
    localparam logic [7:0] OFF_DC_LEVEL  = 8'h14;
    localparam logic [7:0] OFF_DC_TIME   = 8'h18;
    localparam logic [7:0] OFF_DUTY      = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;
    localparam logic [7:0] OFF_STATUS    = 8'h28;
    localparam logic [7:0] OFF_FAULTS    = 8'h2c;
    localparam logic [7:0] OFF_IOMAP     = 8'h30;

    // control register fields
    localparam int unsigned CTRL_THERM_LSB = 0;
    localparam int unsigned CTRL_POLICY    = 2;
    localparam int unsigned CTRL_LOCK      = 3;
    localparam logic [1:0]  THERM_MODE_TRIP = 2'h1;
    localparam logic        POLICY_READ_ONLY = 1'b0;
    localparam logic        POLICY_QUICK     = 1'b1;

    // terminal function codes
    localparam logic [7:0] FUNC_DEW_CMD    = 8'h27;
    localparam logic [7:0] FUNC_MINOR_FLAG = 8'h62;

    // interrupt bits
    localparam int unsigned IRQ_MINOR = 0;
    localparam int unsigned IRQ_TRIP  = 1;
    localparam int unsigned IRQ_DEW   = 2;
    localparam int unsigned IRQ_W     = 3;

    // fault positions in {sel4, sel3, sel2, sel1}
    localparam int unsigned B_EXT   = 1;
    localparam int unsigned B_HOT   = 2;
    localparam int unsigned B_MOL   = 5;
    localparam int unsigned B_OPTL  = 10;
    localparam int unsigned B_OPT   = 11;
    localparam int unsigned B_SP1   = 12;
    localparam int unsigned B_SP2   = 13;
    localparam int unsigned B_CIB   = 19;
    localparam int unsigned B_FAN   = 20;
    localparam int unsigned B_OLW   = 21;
    localparam int unsigned B_HSW   = 22;
    localparam int unsigned B_WEAR  = 23;
    localparam int unsigned B_SPD   = 24;
    localparam int unsigned B_PIDA  = 25;
    localparam int unsigned B_LOWT  = 26;
    localparam int unsigned B_THERM = 27;
    localparam int unsigned B_RUN   = 28;
    localparam int unsigned B_START = 29;
    localparam int unsigned B_BATT  = 31;
    localparam logic [31:0] USED_BITS = 32'hbff83c26;

    // reset values and full-scale duty
    localparam logic [7:0]  SEL_RESET   = 8'h00;
    localparam logic [6:0]  DUTY_FULL   = 7'h64;
    localparam logic [6:0]  DUTY_RESET  = 7'h00;

    typedef struct packed {
        logic       motor1_overload;
        logic       internal_overheat;
        logic       external_fault;
        logic       serial_port2_err;
        logic       serial_port1_err;
        logic       option_fault;
        logic       option_link_fault;
        logic       wearout_alarm;
        logic       heatsink_warn;
        logic       motor_ol_warn;
        logic       fan_stall;
        logic       current_input_break;
        logic [4:0] pid_feedback_err;
        logic       backup_low;
        logic       clock_data_lost;
        logic       startup_count_limit;
        logic       run_time_limit;
        logic       thermistor_trip;
        logic       low_torque;
        logic [4:0] pid_alarm;
        logic       speed_cmd_loss;
    } dag_fault_in_s;

    typedef struct packed {
        logic [7:0]  level;
        logic [15:0] time_ticks;
        logic [6:0]  duty;
    } dag_dew_cfg_s;

endpackage

// File: dag_fault_grade.sv
// combinational sorting of fault flags into minor alarm and trip
`timescale 1ns/1ps
module dag_fault_grade (
    input  dag_pkg::dag_fault_in_s faults,
    input  logic [31:0]            sel,
    input  logic [1:0]             therm_mode,
    output logic [31:0]            fault_vec,
    output logic [31:0]            sel_eff,
    output logic                   minor,
    output logic                   trip
);
    logic [31:0] minor_term;
    logic [31:0] trip_term;

    always_comb begin
        fault_vec = '0;
        fault_vec[dag_pkg::B_MOL]   = faults.motor1_overload;
        fault_vec[dag_pkg::B_HOT]   = faults.internal_overheat;
        fault_vec[dag_pkg::B_EXT]   = faults.external_fault;
        fault_vec[dag_pkg::B_SP2]   = faults.serial_port2_err;
        fault_vec[dag_pkg::B_SP1]   = faults.serial_port1_err;
        fault_vec[dag_pkg::B_OPT]   = faults.option_fault;
        fault_vec[dag_pkg::B_OPTL]  = faults.option_link_fault;
        fault_vec[dag_pkg::B_WEAR]  = faults.wearout_alarm;
        fault_vec[dag_pkg::B_HSW]   = faults.heatsink_warn;
        fault_vec[dag_pkg::B_OLW]   = faults.motor_ol_warn;
        fault_vec[dag_pkg::B_FAN]   = faults.fan_stall;
        fault_vec[dag_pkg::B_CIB]   = faults.current_input_break
                                    | (|faults.pid_feedback_err);
        fault_vec[dag_pkg::B_BATT]  = faults.backup_low
                                    | faults.clock_data_lost;
        fault_vec[dag_pkg::B_START] = faults.startup_count_limit;
        fault_vec[dag_pkg::B_RUN]   = faults.run_time_limit;
        fault_vec[dag_pkg::B_THERM] = faults.thermistor_trip;
        fault_vec[dag_pkg::B_LOWT]  = faults.low_torque;
        fault_vec[dag_pkg::B_PIDA]  = |faults.pid_alarm;
        fault_vec[dag_pkg::B_SPD]   = faults.speed_cmd_loss;
    end

    // unused positions never count; thermistor in trip mode ignores its bit
    always_comb begin
        sel_eff = sel & dag_pkg::USED_BITS;
        if (therm_mode == dag_pkg::THERM_MODE_TRIP) begin
            sel_eff[dag_pkg::B_THERM] = 1'b0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            assign minor_term[i] = fault_vec[i] & sel_eff[i];
            assign trip_term[i]  = fault_vec[i] & ~sel_eff[i];
        end
    endgenerate

    assign minor = |minor_term;
    assign trip  = |trip_term;
endmodule

// File: dag_dew_pulse.sv
// dew condensation prevention pulse timer
`timescale 1ns/1ps
module dag_dew_pulse #(
    parameter int unsigned TICK_CYCLES = dag_pkg::TICK_CYCLES
) (
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          enable,
    input  dag_pkg::dag_dew_cfg_s cfg,
    output logic               pulse_on,
    output logic               pulse_start
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    typedef enum logic [1:0] {DEW_IDLE, DEW_ON, DEW_OFF} dag_dew_e;

    dag_dew_e      state_q, state_d;
    logic [TW-1:0] tick_q;
    logic [15:0]   on_cnt_q, on_cnt_d;
    logic [23:0]   acc_q, acc_d;

    wire tick     = tick_q == TW'(TICK_CYCLES - 1);
    wire full     = cfg.duty >= dag_pkg::DUTY_FULL;
    wire runnable = enable && cfg.duty != '0 && cfg.time_ticks != '0;
    wire on_done  = tick && (on_cnt_q + 16'h0001) >= cfg.time_ticks;
    wire [23:0] rest = full ? 24'h0
                     : 24'(dag_pkg::DUTY_FULL - cfg.duty);

    // off time is paid back from an accumulator, one duty per tick, so no
    // divider is needed; a remainder below one tick rounds the off time up
    always_comb begin
        state_d  = state_q;
        on_cnt_d = on_cnt_q;
        acc_d    = acc_q;
        case (state_q)
            DEW_IDLE: begin
                on_cnt_d = '0;
                acc_d    = '0;
                if (runnable) begin
                    state_d = DEW_ON;
                end
            end
            DEW_ON: begin
                if (tick) begin
                    on_cnt_d = on_cnt_q + 16'h0001;
                    acc_d    = acc_q + rest;
                end
                if (on_done) begin
                    on_cnt_d = '0;
                    state_d  = full ? DEW_ON : DEW_OFF;
                end
            end
            DEW_OFF: begin
                if (tick) begin
                    if (acc_q <= 24'(cfg.duty)) begin
                        state_d = DEW_ON;
                        acc_d   = '0;
                    end else begin
                        acc_d = acc_q - 24'(cfg.duty);
                    end
                end
            end
            default: state_d = DEW_IDLE;
        endcase
        if (!runnable) begin
            state_d = DEW_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state_q == DEW_IDLE || tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + TW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q     <= DEW_IDLE;
            on_cnt_q    <= '0;
            acc_q       <= '0;
            pulse_on    <= 1'b0;
            pulse_start <= 1'b0;
        end else begin
            state_q     <= state_d;
            on_cnt_q    <= on_cnt_d;
            acc_q       <= acc_d;
            pulse_on    <= state_d == DEW_ON;
            pulse_start <= state_d == DEW_ON && state_q != DEW_ON;
        end
    end

    a_on_time_end: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == DEW_ON && state_d == DEW_OFF)
            |-> tick && on_cnt_q + 16'h0001 >= cfg.time_ticks)
        else $error("pulse ended before its on time");

    a_off_paid_back: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == DEW_OFF && state_d == DEW_ON)
            |-> acc_q <= 24'(cfg.duty))
        else $error("off time ended before duty debt was paid");

    a_dew_disabled: assert property (
        @(posedge ref_clk) disable iff (reset)
        !enable |=> !pulse_on)
        else $error("pulse while prevention disabled");
endmodule

// File: dag_alarm_top.sv
// alarm grading, password policy and dew prevention with AHB-Lite registers
`timescale 1ns/1ps
// Function
// - a fault counts as minor alarm only when its mask bit is one
// - each of the four selection masks holds any eight-bit pattern
// - mask one: bit 5 overload, bit 2 overheat, bit 1 external fault
// - mask two: bits 5..2 serial port 2, port 1, option, option link
// - mask three: wear, heat-sink warn, overload warn, fan, input break/PID
// - mask four: battery/clock, starts, run time, thermistor, torque, PID, speed
// - thermistor trip mode forces an immediate trip, ignoring its mask bit
// - minor flag output, terminal function 98, active on any selected alarm
// - password mode 0 all parameters read-only but the lock bit; mode 1 quick setup only
// - dew pulses only while stopped and command 39 is asserted
// - pulse magnitude is brake level, its on time is brake time
// - pulse period chosen so on time over period equals duty
module dag_alarm_top #(
    parameter int unsigned TICK_CYCLES = dag_pkg::TICK_CYCLES
) (
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    input  dag_pkg::dag_fault_in_s faults,
    input  wire logic          drive_stopped,
    input  wire logic          din_level,
    output logic               minor_fault_flag,
    output logic               trip_stop,
    output logic               term_out,
    output logic               dew_dc_on,
    output logic [7:0]         dew_dc_level,
    output logic               irq
);
    // registers
    logic [7:0]  sel_q [4];
    logic [1:0]  therm_mode_q;
    logic        policy_q;
    logic        lock_q;
    logic [7:0]  dc_level_q;
    logic [15:0] dc_time_q;
    logic [6:0]  duty_q;
    logic [dag_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q;
    logic [7:0]  in_func_q;
    logic [7:0]  out_func_q;

    // bus state and previous minor/trip levels
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [7:0]  addr_q;
    logic        minor_prev_q;
    logic        trip_prev_q;

    // grading and dew pulse
    logic [31:0] fault_vec;
    logic [31:0] sel_eff;
    logic        minor_w;
    logic        trip_w;
    logic        pulse_on;
    logic        pulse_start;

    wire [31:0] sel_all = {sel_q[3], sel_q[2], sel_q[1], sel_q[0]};

    dag_fault_grade u_grade (
        .faults     (faults),
        .sel        (sel_all),
        .therm_mode (therm_mode_q),
        .fault_vec  (fault_vec),
        .sel_eff    (sel_eff),
        .minor      (minor_w),
        .trip       (trip_w)
    );

    wire dew_cmd    = din_level && in_func_q == dag_pkg::FUNC_DEW_CMD;
    wire dew_enable = drive_stopped && dew_cmd;

    dag_dew_pulse #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_dew (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .enable      (dew_enable),
        .cfg         ({dc_level_q, dc_time_q, duty_q}),
        .pulse_on    (pulse_on),
        .pulse_start (pulse_start)
    );

    // address phase and decode
    wire addr_take = hsel && htrans[1] && hready;
    wire addr_in_range = haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00;
    wire [7:0] wa = addr_q;

    wire wa_sel   = wa == dag_pkg::OFF_SEL1 || wa == dag_pkg::OFF_SEL2
                 || wa == dag_pkg::OFF_SEL3 || wa == dag_pkg::OFF_SEL4;
    wire wa_quick = wa == dag_pkg::OFF_DC_LEVEL || wa == dag_pkg::OFF_DC_TIME
                 || wa == dag_pkg::OFF_DUTY;
    wire wa_param = wa_sel || wa_quick || wa == dag_pkg::OFF_CTRL
                 || wa == dag_pkg::OFF_IOMAP;

    // quick-setup items stay writable in policy 1; policy 0 freezes all but the lock bit
    wire param_wr_ok = !lock_q
                    || (policy_q == dag_pkg::POLICY_QUICK && wa_quick);
    wire param_hidden = lock_q && policy_q == dag_pkg::POLICY_QUICK
                     && wa_param && !wa_quick;

    wire wr_ok  = wr_pend_q && (!wa_param || param_wr_ok);
    wire wr_sel = wr_ok && wa_sel;
    wire [1:0] sel_idx = wa[3:2];

    wire [31:0] status_word = {28'h0, pulse_on, dew_enable,
                               trip_stop, minor_fault_flag};

    wire [31:0] rd_mux =
        param_hidden                ? 32'h0 :
        wa == dag_pkg::OFF_SEL1     ? {24'h0, sel_q[0]} :
        wa == dag_pkg::OFF_SEL2     ? {24'h0, sel_q[1]} :
        wa == dag_pkg::OFF_SEL3     ? {24'h0, sel_q[2]} :
        wa == dag_pkg::OFF_SEL4     ? {24'h0, sel_q[3]} :
        wa == dag_pkg::OFF_CTRL     ? {28'h0, lock_q, policy_q,
                                       therm_mode_q} :
        wa == dag_pkg::OFF_DC_LEVEL ? {24'h0, dc_level_q} :
        wa == dag_pkg::OFF_DC_TIME  ? {16'h0, dc_time_q} :
        wa == dag_pkg::OFF_DUTY     ? {25'h0, duty_q} :
        wa == dag_pkg::OFF_IRQ_STAT ? {29'h0, stat_q} :
        wa == dag_pkg::OFF_IRQ_MASK ? {29'h0, mask_q} :
        wa == dag_pkg::OFF_STATUS   ? status_word :
        wa == dag_pkg::OFF_FAULTS   ? fault_vec :
        wa == dag_pkg::OFF_IOMAP    ? {16'h0, out_func_q, in_func_q} :
                                      32'h0;

    // reads take one wait state so a write just before is visible
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= addr_take && hwrite && addr_in_range;
            rd_pend_q <= addr_take && !hwrite;
            hreadyout <= !(addr_take && !hwrite);
            if (addr_take) begin
                addr_q <= addr_in_range ? haddr[7:0] : 8'hff;
            end
            if (rd_pend_q) begin
                hrdata <= rd_mux;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    sel_q[g] <= dag_pkg::SEL_RESET;
                end else if (wr_sel && sel_idx == 2'(g)) begin
                    sel_q[g] <= hwdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            therm_mode_q <= '0;
            policy_q     <= dag_pkg::POLICY_READ_ONLY;
            dc_level_q   <= '0;
            dc_time_q    <= '0;
            duty_q       <= dag_pkg::DUTY_RESET;
            in_func_q    <= '0;
            out_func_q   <= '0;
        end else if (wr_ok) begin
            if (wa == dag_pkg::OFF_CTRL) begin
                therm_mode_q <= hwdata[dag_pkg::CTRL_THERM_LSB +: 2];
                policy_q     <= hwdata[dag_pkg::CTRL_POLICY];
            end
            if (wa == dag_pkg::OFF_DC_LEVEL) begin
                dc_level_q <= hwdata[7:0];
            end
            if (wa == dag_pkg::OFF_DC_TIME) begin
                dc_time_q <= hwdata[15:0];
            end
            if (wa == dag_pkg::OFF_DUTY) begin
                duty_q <= hwdata[6:0];
            end
            if (wa == dag_pkg::OFF_IOMAP) begin
                in_func_q  <= hwdata[7:0];
                out_func_q <= hwdata[15:8];
            end
        end
    end

    // the lock bit is the password gate itself, so it is never frozen
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lock_q <= 1'b0;
        end else if (wr_pend_q && wa == dag_pkg::OFF_CTRL) begin
            lock_q <= hwdata[dag_pkg::CTRL_LOCK];
        end
    end

    // sticky events, a new event beats a same-cycle clear
    wire [dag_pkg::IRQ_W-1:0] irq_ev = {pulse_start,
                                        trip_w && !trip_prev_q,
                                        minor_w && !minor_prev_q};
    wire [dag_pkg::IRQ_W-1:0] irq_clr =
        (wr_pend_q && wa == dag_pkg::OFF_IRQ_STAT)
            ? hwdata[dag_pkg::IRQ_W-1:0] : '0;
    assign stat_d = (stat_q & ~irq_clr) | irq_ev;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stat_q       <= '0;
            mask_q       <= '0;
            irq          <= 1'b0;
            minor_prev_q <= 1'b0;
            trip_prev_q  <= 1'b0;
        end else begin
            stat_q       <= stat_d;
            irq          <= |(stat_q & mask_q);
            minor_prev_q <= minor_w;
            trip_prev_q  <= trip_w;
            if (wr_pend_q && wa == dag_pkg::OFF_IRQ_MASK) begin
                mask_q <= hwdata[dag_pkg::IRQ_W-1:0];
            end
        end
    end

    // outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            minor_fault_flag <= 1'b0;
            trip_stop        <= 1'b0;
            term_out         <= 1'b0;
            dew_dc_on        <= 1'b0;
            dew_dc_level     <= '0;
        end else begin
            minor_fault_flag <= minor_w;
            trip_stop        <= trip_w;
            term_out         <= out_func_q == dag_pkg::FUNC_MINOR_FLAG
                                && minor_w;
            dew_dc_on        <= pulse_on;
            dew_dc_level     <= pulse_on ? dc_level_q : 8'h00;
        end
    end

    a_minor_selected: assert property (
        @(posedge ref_clk) disable iff (reset)
        |(fault_vec & sel_all & dag_pkg::USED_BITS
          & ~(32'(therm_mode_q == dag_pkg::THERM_MODE_TRIP)
              << dag_pkg::B_THERM))
            |=> minor_fault_flag)
        else $error("selected fault did not raise minor flag");

    a_unselected_trip: assert property (
        @(posedge ref_clk) disable iff (reset)
        |(fault_vec & ~sel_all) |=> trip_stop)
        else $error("unselected fault did not trip");

    a_no_minor_flag: assert property (
        @(posedge ref_clk) disable iff (reset)
        (fault_vec & sel_all) == 32'h0 |=> !minor_fault_flag)
        else $error("minor flag without selected fault");

    a_therm_trip_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        (therm_mode_q == dag_pkg::THERM_MODE_TRIP
         && faults.thermistor_trip) |=> trip_stop)
        else $error("thermistor in trip mode did not trip");

    a_sel_write_full: assert property (
        @(posedge ref_clk) disable iff (reset)
        (wr_sel && sel_idx == 2'd3)
            |=> {24'h0, sel_q[3]} == ($past(hwdata) & 32'h000000ff))
        else $error("selection mask lost written bits");

    a_ro_policy_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        (wr_pend_q && lock_q && policy_q == dag_pkg::POLICY_READ_ONLY
         && wa == dag_pkg::OFF_DUTY) |=> $stable(duty_q))
        else $error("parameter changed under read-only password");

    a_hidden_reads_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        (rd_pend_q && param_hidden) |=> hrdata == 32'h0 && hreadyout)
        else $error("hidden parameter visible");

    a_dew_needs_stop: assert property (
        @(posedge ref_clk) disable iff (reset)
        !drive_stopped [*2] |=> !dew_dc_on)
        else $error("dew pulse while drive running");

    a_level_only_on: assert property (
        @(posedge ref_clk) disable iff (reset)
        !dew_dc_on |-> dew_dc_level == 8'h00)
        else $error("dc level without pulse");

    a_term_flag_func: assert property (
        @(posedge ref_clk) disable iff (reset)
        term_out |-> minor_fault_flag
            && $past(out_func_q) == dag_pkg::FUNC_MINOR_FLAG)
        else $error("terminal flag without function 98");

    a_irq_set_wins: assert property (
        @(posedge ref_clk) disable iff (reset)
        irq_ev[dag_pkg::IRQ_TRIP] |=> stat_q[dag_pkg::IRQ_TRIP])
        else $error("trip event lost");
endmodule

// File: dag_alarm_top_tb_top.sv
// self-checking bench of the alarm grading block
`timescale 1ns/1ps
module dag_alarm_top_tb_top;
    logic                   ref_clk = 1'b0;
    logic                   reset = 1'b1;
    logic                   hsel = 1'b0;
    logic                   hwrite = 1'b0;
    logic                   drive_stopped = 1'b0;
    logic                   din_level = 1'b0;
    logic [1:0]             htrans = 2'h0;
    logic [31:0]            haddr = 32'h0;
    logic [31:0]            hwdata = 32'h0;
    logic [31:0]            hrdata, rd, sel, v, e;
    logic                   hreadyout, hresp, minor_fault_flag, trip_stop;
    logic                   term_out, dew_dc_on, irq, md;
    logic [7:0]             dew_dc_level;
    dag_pkg::dag_fault_in_s faults = '0;
    dag_pkg::dag_fault_in_s f;
    int                     n_errors = 0;
    int                     checks = 0;
    int                     cnt, off;

    dag_alarm_top #(.TICK_CYCLES(4)) i_dag_alarm_top (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .faults(faults), .drive_stopped(drive_stopped),
        .din_level(din_level), .minor_fault_flag(minor_fault_flag),
        .trip_stop(trip_stop), .term_out(term_out), .dew_dc_on(dew_dc_on),
        .dew_dc_level(dew_dc_level), .irq(irq));

    initial forever #5 ref_clk = ~ref_clk;

    task automatic conclude();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // whole-word single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    function automatic logic [31:0] expv(dag_pkg::dag_fault_in_s f);
        return {f.backup_low | f.clock_data_lost, 1'b0,
            f.startup_count_limit, f.run_time_limit, f.thermistor_trip,
            f.low_torque, |f.pid_alarm, f.speed_cmd_loss, f.wearout_alarm,
            f.heatsink_warn, f.motor_ol_warn, f.fan_stall,
            f.current_input_break | (|f.pid_feedback_err), 5'h0,
            f.serial_port2_err, f.serial_port1_err, f.option_fault,
            f.option_link_fault, 4'h0, f.motor1_overload, 2'h0,
            f.internal_overheat, f.external_fault, 1'b0};
    endfunction

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end

    initial begin
        sel = $urandom(55);
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int a = 0; a <= 8'h34; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
            chk(32'(hresp), 32'h0);
        end
        bus(1'b1, 8'h30, 32'h6227);
        for (int i = 0; i < 40; i++) begin
            sel = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom;
            md = (i == 0) ? 1'b1 : 1'($urandom);
            f = 29'($urandom & $urandom & $urandom);
            if (i == 0)
                f = 29'h80;
            for (int k = 0; k < 4; k++)
                bus(1'b1, 8'(4 * k), {24'h0, sel[8*k +: 8]});
            bus(1'b1, 8'h10, {31'h0, md});
            faults <= f;
            settle();
            v = expv(f);
            e = sel & ~(md ? 32'h08000000 : 32'h0);
            chk(32'(minor_fault_flag), 32'(|(v & e)));
            chk(32'(trip_stop), 32'(|(v & ~e)));
            chk(32'(term_out), 32'(|(v & e)));
            bus(1'b0, 8'(4 * (i % 4)), 32'h0);
            chk(rd, {24'h0, sel[8*(i%4) +: 8]});
        end
        faults <= '0;
        bus(1'b1, 8'h00, 32'hff);
        bus(1'b1, 8'h20, 32'h7);
        faults.external_fault <= 1'b1;
        settle();
        chk(32'(irq), 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd & 32'h1, 32'h1);
        bus(1'b1, 8'h24, 32'h1);
        settle();
        chk(32'(irq), 32'h1);
        @(posedge ref_clk);
        faults <= '0;
        bus(1'b1, 8'h20, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
        // lock with policy 0 freezes masks, policy 1 hides them
        bus(1'b1, 8'h10, 32'h8);
        bus(1'b1, 8'h00, 32'h55);
        bus(1'b1, 8'h1c, 32'h5);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'hff);
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        // policy is frozen while locked in policy 0, so unlock first
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h10, 32'hc);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h1c, 32'h64);
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h64);
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h14, 32'h5a);
        bus(1'b1, 8'h18, 32'h2);
        drive_stopped <= 1'b1;
        din_level <= 1'b1;
        settle();
        chk(32'({dew_dc_on, dew_dc_level}), 32'h15a);
        @(posedge ref_clk);
        drive_stopped <= 1'b0;
        settle();
        chk(32'({dew_dc_on, dew_dc_level}), 32'h0);
        bus(1'b1, 8'h1c, 32'h19);
        drive_stopped <= 1'b1;
        cnt = 0;
        repeat (400) begin
            @(negedge ref_clk);
            cnt += 32'(dew_dc_on);
        end
        chk(32'(cnt >= 90 && cnt <= 110), 32'h1);
        while (dew_dc_on === 1'b1) @(negedge ref_clk);
        while (dew_dc_on !== 1'b1) @(negedge ref_clk);
        cnt = 0;
        while (dew_dc_on === 1'b1) begin
            cnt++;
            @(negedge ref_clk);
        end
        chk(32'(cnt >= 7 && cnt <= 9), 32'h1);
        off = 0;
        while (dew_dc_on !== 1'b1) begin
            off++;
            @(negedge ref_clk);
        end
        chk(32'(cnt * 32'h64), 32'(32'h19 * (cnt + off)));
        conclude();
    end
endmodule
